// *** src/dsrm_pkg.sv ***
// Purpose: Shared constants and types for the DS3 ATM receive status monitor.
// Assumes: 100 MHz system clock, inputs synchronous to it.
// Notes: Status word layout is common to every receive port.
package dsrm_pkg;

  // Receive ports and clock rate
  localparam int NUM_PORTS_DEF = 2;
  localparam int CLK_MHZ = 100;

  // Framing-lost persistence: flagged once sync is missing for more than this
  localparam int FRAMING_LOST_TIME_US = 3000;
  localparam int FRAMING_LOST_CYCLES = FRAMING_LOST_TIME_US * CLK_MHZ;

  // Cell delineation
  localparam int DELIN_LOST_CELLS = 22;
  localparam int DELIN_CNT_W = 5;
  localparam int SYNC_ALPHA_DEF = 7;
  localparam int SYNC_DELTA_DEF = 6;
  localparam int RUN_CNT_W = 4;

  // Status word bit positions
  localparam int STATUS_W = 12;
  localparam int ST_NO_INPUT = 0;
  localparam int ST_DS3_LOST = 1;
  localparam int ST_DS3_MISS = 2;
  localparam int ST_PLCP_LOST = 3;
  localparam int ST_PLCP_MISS = 4;
  localparam int ST_DELIN_LOST = 5;
  localparam int ST_HDR_ERR = 6;
  localparam int ST_HDR_FIXED = 7;
  localparam int ST_LINE_DET = 8;
  localparam int ST_CELL_LOCK = 9;
  localparam int ST_IDLE_CELL = 10;
  localparam int ST_DATA_CELL = 11;

  // Status reset value
  localparam logic [STATUS_W-1:0] STATUS_RST = 12'h000;

  // Bits that carry no meaning under direct cell mapping
  localparam logic [STATUS_W-1:0] PLCP_MASK = 12'h018;

  // Cell delineation states
  typedef enum logic [2:0]
  {
    CELL_HUNT = 3'b001,
    CELL_PRESYNC = 3'b010,
    CELL_SYNC = 3'b100
  } dsrm_cell_state_type;

endpackage

// *** src/dsrm_persist_timer.sv ***
// Purpose: Flags a condition that has held continuously for more than CYCLES clocks.
// Assumes: cond_in is synchronous to clk_in.
// Notes: Any drop of the condition restarts the count from zero.
`timescale 1ns/1ps
module dsrm_persist_timer #(
  parameter int CYCLES = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Condition and result
  input wire logic cond_in,
  output logic flag_out
);

  localparam int CNT_W = $clog2(CYCLES + 2);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(CYCLES);

  logic [CNT_W-1:0] cnt_q;
  logic flag_q;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_q <= '0;
    end
    else if (!cond_in)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q != CNT_TOP)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Saturated count means CYCLES edges already passed; this edge is one more
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      flag_q <= 1'b0;
    end
    else
    begin
      flag_q <= cond_in && (cnt_q == CNT_TOP);
    end
  end

  assign flag_out = flag_q;

endmodule

// *** src/dsrm_sticky_status.sv ***
// Purpose: Accumulates status events between reads and presents a snapshot.
// Assumes: read_in is a one-cycle pulse.
// Notes: An event in the read cycle goes into the snapshot and into the new interval.
`timescale 1ns/1ps
module dsrm_sticky_status
  import dsrm_pkg::*;
#(
  parameter int W = STATUS_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Events, forced-zero mask and read strobe
  input wire logic [W-1:0] event_in,
  input wire logic [W-1:0] zero_mask_in,
  input wire logic read_in,
  // Snapshot of the last completed interval
  output logic [W-1:0] snap_out
);

  logic [W-1:0] acc_q;
  logic [W-1:0] acc_d;
  logic [W-1:0] snap_q;
  logic [W-1:0] seen;

  assign seen = (acc_q | event_in) & ~zero_mask_in;

  // Set wins over the read clear
  always_comb
  begin
    acc_d = read_in ? (event_in & ~zero_mask_in) : seen;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      acc_q <= W'(STATUS_RST);
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  // Masked bits also clear in a held snapshot when the mode changes
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      snap_q <= W'(STATUS_RST);
    end
    else if (read_in)
    begin
      snap_q <= seen;
    end
    else
    begin
      snap_q <= snap_q & ~zero_mask_in;
    end
  end

  assign snap_out = snap_q;

endmodule

// *** src/dsrm_monitor.sv ***
// Purpose: Receive status and alarm monitor for DS3 lines carrying ATM cells.
// Assumes: Framer, line unit and cell slicer inputs are synchronous to clk_in.
// Notes: One independent set of settings and flags per receive port.
`timescale 1ns/1ps

// Summary of operation
// - Status conditions are latched and held until the next read of that port.
// - No-input flag when signal absent or too weak to recognise.
// - DS3 frame-sync-missing flag whenever the DS3 framer lacks sync.
// - DS3 framing-lost after sync missing continuously over three milliseconds.
// - PLCP frame-sync-missing flag whenever the PLCP framer lacks sync.
// - PLCP framing-lost after PLCP sync missing continuously over three milliseconds.
// - Both PLCP flags read zero under direct cell mapping.
// - Delineation-lost flag after 22 or more consecutive cells without delineation.
// - Delineation lost means the cell state machine holds no lock.
// - Cell lock flag once the cell engine locks to the stream.
// - Header check error flag for each cell failing its header check.
// - Line-input-detected flag from the line unit on a valid signal.
// - Idle-cell flag while an idle cell is received.
// - Data-cell flag while a non-idle cell is received.
// - DS3 framer mode per port: multiplex or C-bit parity framing.
// - Direct mapping takes cells from DS3 payload, else via PLCP.
// - Header correction setting repairs single-bit header errors.
// - Errored-cell-accept setting passes or discards header-failed cells.
// - Idle passthrough setting forwards idle cells instead of dropping.
module dsrm_monitor #(
  parameter int NUM_PORTS = dsrm_pkg::NUM_PORTS_DEF,
  parameter int FRAMING_LOST_CYCLES = dsrm_pkg::FRAMING_LOST_CYCLES,
  parameter int SYNC_ALPHA = dsrm_pkg::SYNC_ALPHA_DEF,
  parameter int SYNC_DELTA = dsrm_pkg::SYNC_DELTA_DEF
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Per-port settings
  input wire logic [NUM_PORTS-1:0] direct_map_in,
  input wire logic [NUM_PORTS-1:0] multiplex_framing_mode_in,
  input wire logic [NUM_PORTS-1:0] header_correct_en_in,
  input wire logic [NUM_PORTS-1:0] errored_accept_in,
  input wire logic [NUM_PORTS-1:0] idle_cell_passthrough_in,
  // Line interface unit
  input wire logic [NUM_PORTS-1:0] line_signal_present_in,
  input wire logic [NUM_PORTS-1:0] line_level_low_in,
  input wire logic [NUM_PORTS-1:0] line_valid_detect_in,
  // Framers
  input wire logic [NUM_PORTS-1:0] ds3_frame_sync_in,
  input wire logic [NUM_PORTS-1:0] plcp_frame_sync_in,
  // Cell slicer, one pulse per cell slot
  input wire logic [NUM_PORTS-1:0] cell_start_in,
  input wire logic [NUM_PORTS-1:0] cell_hdr_ok_in,
  input wire logic [NUM_PORTS-1:0] cell_hdr_single_in,
  input wire logic [NUM_PORTS-1:0] cell_idle_in,
  // Status read strobes
  input wire logic [NUM_PORTS-1:0] status_read_in,
  // Framer and mapper control
  output logic [NUM_PORTS-1:0] framer_multiplex_mode_out,
  output logic [NUM_PORTS-1:0] plcp_extract_en_out,
  // Cell forwarding decisions
  output logic [NUM_PORTS-1:0] cell_pass_out,
  output logic [NUM_PORTS-1:0] cell_hdr_fix_out,
  // Status snapshots, STATUS_W bits per port
  output logic [NUM_PORTS*dsrm_pkg::STATUS_W-1:0] status_flags_out
);

  import dsrm_pkg::*;

  localparam logic [DELIN_CNT_W-1:0] DELIN_TOP = DELIN_CNT_W'(DELIN_LOST_CELLS);
  localparam logic [RUN_CNT_W-1:0] ALPHA_TOP = RUN_CNT_W'(SYNC_ALPHA - 1);
  localparam logic [RUN_CNT_W-1:0] DELTA_TOP = RUN_CNT_W'(SYNC_DELTA - 1);

  // Header acceptable for delineation and forwarding
  function automatic logic hdr_usable(input logic ok, input logic single, input logic fix_en);
    hdr_usable = ok || (single && fix_en);
  endfunction

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      dsrm_cell_state_type state_q;
      dsrm_cell_state_type state_d;
      logic [RUN_CNT_W-1:0] run_q;
      logic [RUN_CNT_W-1:0] run_d;
      logic [DELIN_CNT_W-1:0] unlock_cells_q;
      logic delin_lost_q;
      logic ds3_lost;
      logic plcp_lost;
      logic plcp_miss;
      logic cell_ok;
      logic cell_fixed;
      logic locked;
      logic pass_q;
      logic fix_q;
      logic [STATUS_W-1:0] events;
      logic [STATUS_W-1:0] zero_mask;

      assign locked = (state_q == CELL_SYNC);
      assign cell_ok = hdr_usable(cell_hdr_ok_in[p], cell_hdr_single_in[p], header_correct_en_in[p]);
      assign cell_fixed = !cell_hdr_ok_in[p] && cell_hdr_single_in[p] && header_correct_en_in[p];

      // PLCP sync only counts when cells come through PLCP
      assign plcp_miss = !direct_map_in[p] && !plcp_frame_sync_in[p];

      // Long persistence timers; shorten FRAMING_LOST_CYCLES for simulation
      dsrm_persist_timer #(
        .CYCLES(FRAMING_LOST_CYCLES)
      ) u_ds3_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .cond_in(!ds3_frame_sync_in[p]),
        .flag_out(ds3_lost)
      );

      dsrm_persist_timer #(
        .CYCLES(FRAMING_LOST_CYCLES)
      ) u_plcp_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .cond_in(plcp_miss),
        .flag_out(plcp_lost)
      );

      // Cell delineation state machine, advanced once per cell slot
      always_comb
      begin
        state_d = state_q;
        run_d = run_q;
        if (cell_start_in[p])
        begin
          case (state_q)
            CELL_HUNT:
            begin
              run_d = '0;
              if (cell_ok)
              begin
                state_d = CELL_PRESYNC;
              end
            end
            CELL_PRESYNC:
            begin
              if (!cell_ok)
              begin
                state_d = CELL_HUNT;
                run_d = '0;
              end
              else if (run_q == DELTA_TOP)
              begin
                state_d = CELL_SYNC;
                run_d = '0;
              end
              else
              begin
                run_d = run_q + 1'b1;
              end
            end
            CELL_SYNC:
            begin
              if (cell_ok)
              begin
                run_d = '0;
              end
              else if (run_q == ALPHA_TOP)
              begin
                state_d = CELL_HUNT;
                run_d = '0;
              end
              else
              begin
                run_d = run_q + 1'b1;
              end
            end
            default:
            begin
              state_d = CELL_HUNT;
              run_d = '0;
            end
          endcase
        end
      end

      always_ff @(posedge clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
        begin
          state_q <= CELL_HUNT;
          run_q <= '0;
        end
        else
        begin
          state_q <= state_d;
          run_q <= run_d;
        end
      end

      // Consecutive cell slots without lock; saturates so it cannot wrap
      always_ff @(posedge clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
        begin
          unlock_cells_q <= '0;
          delin_lost_q <= 1'b0;
        end
        else if (locked)
        begin
          unlock_cells_q <= '0;
          delin_lost_q <= 1'b0;
        end
        else if (cell_start_in[p] && unlock_cells_q != DELIN_TOP)
        begin
          unlock_cells_q <= unlock_cells_q + 1'b1;
          delin_lost_q <= (unlock_cells_q + 1'b1) == DELIN_TOP;
        end
      end

      // Forwarding decision registered one cycle after the cell slot
      always_ff @(posedge clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
        begin
          pass_q <= 1'b0;
          fix_q <= 1'b0;
        end
        else
        begin
          pass_q <= cell_start_in[p] && locked
                    && (cell_ok || errored_accept_in[p])
                    && (!cell_idle_in[p] || idle_cell_passthrough_in[p]);
          fix_q <= cell_start_in[p] && locked && cell_fixed;
        end
      end

      assign cell_pass_out[p] = pass_q;
      assign cell_hdr_fix_out[p] = fix_q;
      assign framer_multiplex_mode_out[p] = multiplex_framing_mode_in[p];
      assign plcp_extract_en_out[p] = !direct_map_in[p];

      // Live conditions feeding the interval accumulator
      always_comb
      begin
        events = STATUS_RST;
        events[ST_NO_INPUT] = !line_signal_present_in[p] || line_level_low_in[p];
        events[ST_DS3_LOST] = ds3_lost;
        events[ST_DS3_MISS] = !ds3_frame_sync_in[p];
        events[ST_PLCP_LOST] = plcp_lost;
        events[ST_PLCP_MISS] = plcp_miss;
        events[ST_DELIN_LOST] = delin_lost_q;
        events[ST_HDR_ERR] = cell_start_in[p] && !cell_hdr_ok_in[p];
        events[ST_HDR_FIXED] = cell_start_in[p] && locked && cell_fixed;
        events[ST_LINE_DET] = line_valid_detect_in[p];
        events[ST_CELL_LOCK] = locked;
        events[ST_IDLE_CELL] = cell_start_in[p] && locked && cell_idle_in[p];
        events[ST_DATA_CELL] = cell_start_in[p] && locked && !cell_idle_in[p];
      end

      assign zero_mask = direct_map_in[p] ? PLCP_MASK : STATUS_RST;

      // Separate accumulator per port, cleared only by its own read
      dsrm_sticky_status #(
        .W(STATUS_W)
      ) u_status (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .event_in(events),
        .zero_mask_in(zero_mask),
        .read_in(status_read_in[p]),
        .snap_out(status_flags_out[p*STATUS_W +: STATUS_W])
      );
    end
  endgenerate

endmodule

// *** sim/dsrm_monitor_assertions.sv ***
// Purpose: Port 0 checks for the receive status monitor
// Assumes: Port 1 shares the same logic
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
module dsrm_monitor_assertions #(
  parameter int NUM_PORTS = 2,
  parameter int FRAMING_LOST_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Watched inputs
  input wire logic [NUM_PORTS-1:0] direct_map_in,
  input wire logic [NUM_PORTS-1:0] line_signal_present_in,
  input wire logic [NUM_PORTS-1:0] line_level_low_in,
  input wire logic [NUM_PORTS-1:0] line_valid_detect_in,
  input wire logic [NUM_PORTS-1:0] ds3_frame_sync_in,
  input wire logic [NUM_PORTS-1:0] cell_start_in,
  input wire logic [NUM_PORTS-1:0] cell_hdr_ok_in,
  input wire logic [NUM_PORTS-1:0] status_read_in,
  // Watched outputs
  input wire logic [NUM_PORTS-1:0] cell_pass_out,
  input wire logic [NUM_PORTS*dsrm_pkg::STATUS_W-1:0] status_flags_out
);
  import dsrm_pkg::*;
  wire logic [STATUS_W-1:0] st = status_flags_out[STATUS_W-1:0];
  wire logic rd = status_read_in[0];
  int miss_q;
  // Saturates so a long outage cannot wrap
  always_ff @(posedge clk_in or posedge sys_rst_in)
    if (sys_rst_in)
      miss_q <= 0;
    else if (ds3_frame_sync_in[0])
      miss_q <= 0;
    else if (miss_q < 1000)
      miss_q <= miss_q + 1;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  a_snap_hold: assert property (!rd && !direct_map_in[0] |=> $stable(st))
    else $error("Status changed without a read");
  a_no_input: assert property (rd && (!line_signal_present_in[0] || line_level_low_in[0]) |=> st[ST_NO_INPUT])
    else $error("No-input flag missing");
  a_sync_miss: assert property (rd && !ds3_frame_sync_in[0] |=> st[ST_DS3_MISS])
    else $error("Sync-missing flag missing");
  a_framing_lost: assert property (rd && !ds3_frame_sync_in[0] && miss_q > FRAMING_LOST_CYCLES + 3 |=> st[ST_DS3_LOST])
    else $error("Framing-lost flag missing");
  a_plcp_zero: assert property (direct_map_in[0] [*2] |=> st[ST_PLCP_MISS:ST_PLCP_LOST] == 2'b00)
    else $error("PLCP flags set under direct mapping");
  a_hdr_err: assert property (rd && cell_start_in[0] && !cell_hdr_ok_in[0] |=> st[ST_HDR_ERR])
    else $error("Header error flag missing");
  a_line_det: assert property (rd && line_valid_detect_in[0] |=> st[ST_LINE_DET])
    else $error("Line detect flag missing");
  a_pass_cause: assert property (cell_pass_out[0] |-> $past(cell_start_in[0]))
    else $error("Cell pass without a cell");
  c_pass: cover property (cell_pass_out[0]);
  c_lock: cover property (st[ST_CELL_LOCK]);
  c_lost: cover property (st[ST_DS3_LOST]);
endmodule

bind dsrm_monitor dsrm_monitor_assertions #(.NUM_PORTS(NUM_PORTS), .FRAMING_LOST_CYCLES(FRAMING_LOST_CYCLES)) u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .direct_map_in(direct_map_in),
  .line_signal_present_in(line_signal_present_in), .line_level_low_in(line_level_low_in),
  .line_valid_detect_in(line_valid_detect_in), .ds3_frame_sync_in(ds3_frame_sync_in),
  .cell_start_in(cell_start_in), .cell_hdr_ok_in(cell_hdr_ok_in), .status_read_in(status_read_in),
  .cell_pass_out(cell_pass_out), .status_flags_out(status_flags_out));

// *** sim/dsrm_line_model.sv ***
// Purpose: Cell slicer side of the DS3 line for both ports
// Assumes: Cell kind inputs change between slots
// Notes: Qualifiers carry noise outside slots, never a held value
`timescale 1ns/1ps
module dsrm_line_model #(
  parameter int GAP = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Kind of the coming cells
  input wire logic [1:0] bad_in,
  input wire logic [1:0] single_in,
  input wire logic [1:0] idle_in,
  // Cell slicer outputs
  output logic [1:0] cell_start_out,
  output logic [1:0] hdr_ok_out,
  output logic [1:0] hdr_single_out,
  output logic [1:0] idle_out
);
  int slot_q;
  always_ff @(posedge clk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      slot_q <= 0;
      cell_start_out <= 2'b00;
      hdr_ok_out <= 2'b00;
      hdr_single_out <= 2'b00;
      idle_out <= 2'b00;
    end
    else
    begin
      slot_q <= (slot_q == GAP - 1) ? 0 : slot_q + 1;
      cell_start_out <= {2{slot_q == GAP - 1}};
      hdr_ok_out <= (slot_q == GAP - 1) ? ~bad_in : 2'($urandom);
      hdr_single_out <= (slot_q == GAP - 1) ? single_in : 2'($urandom);
      idle_out <= (slot_q == GAP - 1) ? idle_in : 2'($urandom);
    end
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the receive status monitor
// Assumes: Framing-lost count shortened to 20 cycles
// Notes: Cells come from the line model, one slot every 8 cycles
`timescale 1ns/1ps
module tb;
  import dsrm_pkg::*;
  localparam int FLC = 20;
  localparam logic [5:0] CORNER [5] = '{6'h20, 6'h21, 6'h1C, 6'h10, 6'h12};
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [1:0] dm = 2'b00, mode = 2'b00, corr = 2'b00, acc = 2'b00, thru = 2'b00, rd = 2'b00;
  logic [1:0] pres = 2'b11, low = 2'b00, det = 2'b11, dsync = 2'b11, psync = 2'b11;
  logic [1:0] bad = 2'b00, sgl = 2'b00, idl = 2'b00;
  logic [1:0] cs, ok, sg, ic, fmm, pxe, pass;
  logic [23:0] flags;
  logic [11:0] s;
  logic [5:0] v;
  int mismatches = 0;
  int compares = 0;
  int nstart = 0;
  int npass = 0;
  always #5 clk_in = ~clk_in;
  dsrm_line_model #(.GAP(8)) line (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bad_in(bad), .single_in(sgl),
    .idle_in(idl), .cell_start_out(cs), .hdr_ok_out(ok), .hdr_single_out(sg), .idle_out(ic));
  dsrm_monitor #(.FRAMING_LOST_CYCLES(FLC)) uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .direct_map_in(dm),
    .multiplex_framing_mode_in(mode), .header_correct_en_in(corr), .errored_accept_in(acc),
    .idle_cell_passthrough_in(thru), .line_signal_present_in(pres), .line_level_low_in(low),
    .line_valid_detect_in(det), .ds3_frame_sync_in(dsync), .plcp_frame_sync_in(psync), .cell_start_in(cs),
    .cell_hdr_ok_in(ok), .cell_hdr_single_in(sg), .cell_idle_in(ic), .status_read_in(rd),
    .framer_multiplex_mode_out(fmm), .plcp_extract_en_out(pxe), .cell_pass_out(pass), .cell_hdr_fix_out(),
    .status_flags_out(flags));
  always @(posedge clk_in)
  begin
    nstart += (cs[0] === 1'b1);
    npass += (pass[0] === 1'b1);
  end
  task automatic conclude();
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Snapshot lands the cycle after the read edge
  task automatic rd_port(input int p);
    @(posedge clk_in);
    rd[p] <= 1'b1;
    @(posedge clk_in);
    rd[p] <= 1'b0;
    @(negedge clk_in);
    s = flags[p*12 +: 12];
  endtask
  task automatic cells(input int n);
    int t;
    t = nstart + n;
    for (int i = 0; i < 10 * n + 20 && nstart < t; i++)
      @(negedge clk_in);
    if (nstart < t)
    begin
      mismatches++;
      conclude();
    end
    else
      repeat (2) @(negedge clk_in);
  endtask
  // Two outages split by one synced cycle, read while still out
  task automatic lost_case(input int n1, input int n2, input logic d);
    @(posedge clk_in);
    dm[0] <= d;
    {dsync[0], psync[0]} <= 2'b11;
    repeat (4) @(posedge clk_in);
    rd_port(0);
    @(posedge clk_in);
    {dsync[0], psync[0]} <= 2'b00;
    repeat (n1) @(posedge clk_in);
    {dsync[0], psync[0]} <= 2'b11;
    @(posedge clk_in);
    {dsync[0], psync[0]} <= 2'b00;
    repeat (n2) @(posedge clk_in);
    rd_port(0);
    chk(s & 12'h01E, {7'h00, !d, n2 > FLC && !d, 1'b1, n2 > FLC, 1'b0});
  endtask
  initial
  begin
    void'($urandom(51990));
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    bad <= 2'b11;
    cells(21);
    rd_port(0);
    chk(s & 12'h260, 12'h040);
    cells(1);
    rd_port(0);
    chk(s & 12'h260, 12'h060);
    // Fewer than seven bad cells keep lock, so each case runs locked
    for (int k = 0; k < 20; k++)
    begin
      @(posedge clk_in);
      bad <= 2'b00;
      cells(8);
      // New kind set right after a slot, so no old-kind cell lands after the read
      v = (k < 5) ? CORNER[k] : 6'($urandom);
      @(posedge clk_in);
      {idl[0], bad[0], sgl[0], corr[0], acc[0], thru[0]} <= v;
      {idl[1], bad[1], sgl[1], corr[1], acc[1], thru[1]} <= 6'($urandom);
      rd_port(0);
      npass = 0;
      cells(5);
      rd_port(0);
      chk(s & 12'hEE0, {!v[5], v[5], 2'b10, v[4] && v[3] && v[2], v[4], 6'h00});
      chk(12'(npass), ((!v[4] || (v[3] && v[2]) || v[1]) && (!v[5] || v[0])) ? 12'h005 : 12'h000);
    end
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clk_in);
      {dm, mode, pres, low, det, dsync, psync} <= 14'($urandom);
      repeat (3) @(posedge clk_in);
      for (int p = 0; p < 2; p++)
      begin
        rd_port(p);
        rd_port(p);
        chk(s & (dm[p] ? 12'h11D : 12'h115), {3'h0, det[p], 3'h0, !psync[p] && !dm[p], 1'b0, !dsync[p], 1'b0, !pres[p] || low[p]});
      end
      chk({8'h00, fmm, pxe}, {8'h00, mode, ~dm});
    end
    lost_case(12, 12, 1'b0);
    lost_case(1, 24, 1'b0);
    lost_case(1, 24, 1'b1);
    lost_case(1, 15, 1'b0);
    conclude();
  end
endmodule
